// >>> hdl/vsc_pkg.sv
// Constants and carrier types of the video sync control register bank
package vsc_pkg;

	// ----------------------------------------------------------
	// Register map
	// ----------------------------------------------------------
	localparam int REG_N = 7;
	localparam logic [7:0] OFF_CTL1 = 8'h00;
	localparam logic [7:0] OFF_CTL2 = 8'h01;
	localparam logic [7:0] OFF_CTL3 = 8'h02;
	localparam logic [7:0] OFF_ZOOM = 8'h03;
	localparam logic [7:0] OFF_PHASE = 8'h04;
	localparam logic [7:0] OFF_BORDER = 8'h05;
	localparam logic [7:0] OFF_HOLD = 8'h06;
	localparam logic [7:0] REG_RST = 8'h00;

	// ----------------------------------------------------------
	// Bus address and figures
	// ----------------------------------------------------------
	// 8-bit write addresses 24h and 26h, kept as 7-bit values
	localparam logic [6:0] DEV_ADDR_LO = 7'h12;
	localparam logic [6:0] DEV_ADDR_HI = 7'h13;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [9:0] LINE_SHORT = 10'h35a;
	localparam logic [9:0] LINE_LONG = 10'h360;
	localparam int PHASE_STEP_SHIFT = 3;
	localparam logic [4:0] HOLD_BASE = 5'h03;
	localparam logic [1:0] CODE_UNDEF = 2'h3;
	localparam logic [1:0] POS_MID = 2'h1;
	localparam logic [1:0] RASTER_BETA_ALPHA = 2'h2;
	localparam logic [3:0] DELAY_UNDEF_LOW = 4'hf;

	// ----------------------------------------------------------
	// Register layouts
	// ----------------------------------------------------------
	typedef enum logic [1:0] {
		WR_NORMAL, WR_NINE, WR_PIC_IN_STILL, WR_STILL_IN_PIC
	} vsc_wmode_t;

	typedef struct packed {
		logic sync_source_sel;
		logic picture_blank;
		logic switch_invert;
		logic switch_toggle;
		logic vsync_filter_sel;
		logic std_sel;
		logic [1:0] raster_sequence;
	} vsc_ctl1_t;

	typedef struct packed {
		logic single_field_enable;
		logic field_change;
		logic field_reference_sel;
		logic [4:0] write_delay;
	} vsc_ctl2_t;

	typedef struct packed {
		logic still_enable;
		logic border_enable;
		vsc_wmode_t write_mode_sel;
		logic [1:0] window_row;
		logic [1:0] window_column;
	} vsc_ctl3_t;

	typedef struct packed {
		logic zoom_enable;
		logic [2:0] zoom_row;
		logic [3:0] zoom_column;
	} vsc_zoom_t;

	typedef struct packed {
		logic long_line_sel;
		logic [6:0] line_sync_shift;
	} vsc_phase_t;

	typedef struct packed {
		logic border_signal_off;
		logic [6:0] border_signal_lag;
	} vsc_border_t;

	typedef struct packed {
		logic [3:0] hold_pulse_width;
		logic [3:0] hold_pulse_position;
	} vsc_hold_t;

endpackage : vsc_pkg

// >>> hdl/vsc_regs.sv
// Serial control register bank with bus slave receiver and link side
// Function
// - Subaddress steps by one after each byte
// - Answer at 24h, or 26h with pin high
// - Reset clears all seven registers
// - Control one bit 7 picks sync source
// - Control one bit 6 blanks picture
// - Switch output held, or set at each display vsync from filtered vsync level
// - Control one bit 3 picks vsync filter
// - Control one bit 2 picks 50/60 Hz
// - Raster code gives field sequence; some undefined
// - Single field mode with change or reference
// - Write delay 0-14, 16-30; 15 and 31 undefined
// - Control three bit 7 freezes still picture
// - Control three bit 6 adds window border
// - Write mode field selects four modes
// - Window positions 0-2; middle barred in inset modes
// - Zoom bit enables zoom, drives zoom output
// - Zoom row 0-7, column 0-11
// - Long line bit gives 858 or 864
// - Sync shift steps of eight double clocks
// - Border signal forced low, lag 0-127
// - Hold pulse width, position code plus three
// - Conversion pin enables standard conversion
`timescale 1ns/100ps
module vsc_regs (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic addr_sel_i,
	input wire logic conversion_select_pin_i,
	output vsc_pkg::vsc_ctl1_t ctl1_o,
	output vsc_pkg::vsc_ctl2_t ctl2_o,
	output vsc_pkg::vsc_ctl3_t ctl3_o,
	output vsc_pkg::vsc_zoom_t zoom_o,
	output vsc_pkg::vsc_phase_t phase_o,
	output vsc_pkg::vsc_border_t border_o,
	output vsc_pkg::vsc_hold_t hold_o,
	output logic conversion_active_o,
	output logic shown_field_o,
	output logic raster_undef_o,
	output logic write_delay_undef_o,
	output logic window_illegal_o,
	output logic zoom_column_undef_o,
	output logic [9:0] line_length_o,
	output logic [9:0] line_sync_cycles_o,
	output logic [4:0] hold_lead_o,
	input wire logic base_pixel_clock_i,
	input wire logic display_vertical_sync_i,
	input wire logic filtered_vertical_sync_i,
	output logic source_switch_out_o,
	output logic zoom_active_o,
	output logic border_signal_force_low_o
);
	import vsc_pkg::*;

	// ----------------------------------------------------------
	// Bus side state
	// ----------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
		ST_DATA, ST_DATA_ACK
	} vsc_state_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic adr_s1;
		logic adr_s2;
		logic conv_s1;
		logic conv_s2;
		vsc_state_t st;
		logic [3:0] bits;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic ack_drv;
		logic [REG_N-1:0][7:0] regs;
		logic fld_chg_d;
		logic fld_shown;
	} vsc_sys_t;

	vsc_sys_t s_r;
	vsc_sys_t s_nxt;

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [6:0] my_addr;
	vsc_ctl1_t c1;
	vsc_ctl2_t c2;
	vsc_ctl3_t c3;
	vsc_zoom_t cz;
	vsc_phase_t cp;
	vsc_border_t cb;
	vsc_hold_t ch;

	always_comb begin
		c1 = vsc_ctl1_t'(s_r.regs[OFF_CTL1[2:0]]);
		c2 = vsc_ctl2_t'(s_r.regs[OFF_CTL2[2:0]]);
		c3 = vsc_ctl3_t'(s_r.regs[OFF_CTL3[2:0]]);
		cz = vsc_zoom_t'(s_r.regs[OFF_ZOOM[2:0]]);
		cp = vsc_phase_t'(s_r.regs[OFF_PHASE[2:0]]);
		cb = vsc_border_t'(s_r.regs[OFF_BORDER[2:0]]);
		ch = vsc_hold_t'(s_r.regs[OFF_HOLD[2:0]]);
	end

	assign scl_rise = s_r.scl_s2 & ~s_r.scl_d;
	assign scl_fall = ~s_r.scl_s2 & s_r.scl_d;
	assign start_cond = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
	assign stop_cond = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
	assign my_addr = s_r.adr_s2 ? DEV_ADDR_HI : DEV_ADDR_LO;

	// ----------------------------------------------------------
	// Receiver and register file
	// ----------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_s1 = scl_i;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_d = s_r.scl_s2;
		s_nxt.sda_s1 = sda_i;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_d = s_r.sda_s2;
		s_nxt.adr_s1 = addr_sel_i;
		s_nxt.adr_s2 = s_r.adr_s1;
		s_nxt.conv_s1 = conversion_select_pin_i;
		s_nxt.conv_s2 = s_r.conv_s1;
		if (stop_cond) begin
			s_nxt.st = ST_IDLE;
			s_nxt.ack_drv = 1'b0;
		end else if (start_cond) begin
			// A repeated start restarts the address phase
			s_nxt.st = ST_ADDR;
			s_nxt.bits = '0;
			s_nxt.ack_drv = 1'b0;
		end else begin
			unique case (s_r.st)
				ST_IDLE: begin
					s_nxt.ack_drv = 1'b0;
				end
				ST_ADDR, ST_SUB, ST_DATA: begin
					if (scl_rise) begin
						s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_s2};
						s_nxt.bits = s_r.bits + 4'h1;
					end else if (scl_fall && s_r.bits == BITS_PER_BYTE) begin
						s_nxt.ack_drv = 1'b1;
						if (s_r.st == ST_ADDR) begin
							// Reads are not served: a read address is not acked
							if (s_r.shreg[7:1] == my_addr && !s_r.shreg[0]) begin
								s_nxt.st = ST_ADDR_ACK;
							end else begin
								s_nxt.st = ST_IDLE;
								s_nxt.ack_drv = 1'b0;
							end
						end else if (s_r.st == ST_SUB) begin
							s_nxt.st = ST_SUB_ACK;
							s_nxt.ptr = s_r.shreg;
						end else begin
							s_nxt.st = ST_DATA_ACK;
							if (s_r.ptr < 8'(REG_N)) begin
								s_nxt.regs[s_r.ptr[2:0]] = s_r.shreg;
							end
							s_nxt.ptr = s_r.ptr + 8'h01;
						end
					end
				end
				ST_ADDR_ACK, ST_SUB_ACK, ST_DATA_ACK: begin
					if (scl_fall) begin
						s_nxt.ack_drv = 1'b0;
						s_nxt.bits = '0;
						s_nxt.st = (s_r.st == ST_ADDR_ACK) ? ST_SUB : ST_DATA;
					end
				end
				default: begin
					s_nxt.st = ST_IDLE;
				end
			endcase
		end
		// Single field mode: toggle on any change, or follow the bit
		s_nxt.fld_chg_d = c2.field_change;
		if (c2.field_reference_sel) begin
			s_nxt.fld_shown = c2.field_change;
		end else if (c2.field_change != s_r.fld_chg_d) begin
			s_nxt.fld_shown = ~s_r.fld_shown;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.scl_s1 <= 1'b1;
			s_r.scl_s2 <= 1'b1;
			s_r.scl_d <= 1'b1;
			s_r.sda_s1 <= 1'b1;
			s_r.sda_s2 <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.st <= ST_IDLE;
			s_r.regs <= {REG_N{REG_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------
	// Bus side outputs
	// ----------------------------------------------------------
	assign sda_o = 1'b0;
	assign sda_oe_o = s_r.ack_drv;

	assign ctl1_o = c1;
	assign ctl2_o = c2;
	assign ctl3_o = c3;
	assign zoom_o = cz;
	assign phase_o = cp;
	assign border_o = cb;
	assign hold_o = ch;
	assign conversion_active_o = s_r.conv_s2;
	assign shown_field_o = s_r.fld_shown;

	// Undefined codes are flagged, not blocked: the register keeps them
	assign raster_undef_o = (c1.raster_sequence == CODE_UNDEF)
		|| (!s_r.conv_s2 && c1.raster_sequence == RASTER_BETA_ALPHA);
	assign write_delay_undef_o =
		(c2.write_delay[3:0] == DELAY_UNDEF_LOW);
	assign window_illegal_o = (c3.window_row == CODE_UNDEF)
		|| (c3.window_column == CODE_UNDEF)
		|| ((c3.write_mode_sel == WR_PIC_IN_STILL
		|| c3.write_mode_sel == WR_STILL_IN_PIC)
		&& (c3.window_row == POS_MID
		|| c3.window_column == POS_MID));
	assign zoom_column_undef_o = &cz.zoom_column[3:2];
	assign line_length_o = cp.long_line_sel ? LINE_LONG
		: LINE_SHORT;
	assign line_sync_cycles_o = 10'({3'h0, cp.line_sync_shift}
		<< PHASE_STEP_SHIFT);
	assign hold_lead_o = {1'b0, ch.hold_pulse_position}
		+ HOLD_BASE;

	// ----------------------------------------------------------
	// Link side on the pixel clock
	// ----------------------------------------------------------
	// Config bits are quasi-static, so a level synchroniser is enough
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic [3:0] cfg_s1;
		logic [3:0] cfg_s2;
		logic dsp_s1;
		logic dsp_s2;
		logic dsp_d;
		logic flt_s1;
		logic flt_s2;
		logic source_switch_out;
	} vsc_link_t;

	vsc_link_t l_r;
	vsc_link_t l_nxt;
	logic [3:0] cfg_src;

	assign cfg_src = {c1.switch_invert, c1.switch_toggle,
		cz.zoom_enable, cb.border_signal_off};

	always_comb begin
		l_nxt = l_r;
		l_nxt.rst_s1 = rst_i;
		l_nxt.rst_s2 = l_r.rst_s1;
		l_nxt.cfg_s1 = cfg_src;
		l_nxt.cfg_s2 = l_r.cfg_s1;
		l_nxt.dsp_s1 = display_vertical_sync_i;
		l_nxt.dsp_s2 = l_r.dsp_s1;
		l_nxt.dsp_d = l_r.dsp_s2;
		l_nxt.flt_s1 = filtered_vertical_sync_i;
		l_nxt.flt_s2 = l_r.flt_s1;
		if (!l_r.cfg_s2[2]) begin
			l_nxt.source_switch_out = l_r.cfg_s2[3];
		end else if (l_r.dsp_s2 && !l_r.dsp_d) begin
			// Level taken at each display vsync depends on input vsync
			l_nxt.source_switch_out = l_r.flt_s2 ? l_r.cfg_s2[3]
				: ~l_r.cfg_s2[3];
		end
		if (l_r.rst_s2) begin
			l_nxt.source_switch_out = 1'b0;
			l_nxt.cfg_s1 = '0;
			l_nxt.cfg_s2 = '0;
		end
	end

	always_ff @(posedge base_pixel_clock_i) begin
		l_r <= l_nxt;
	end

	assign source_switch_out_o = l_r.source_switch_out;
	assign zoom_active_o = l_r.cfg_s2[1];
	assign border_signal_force_low_o = l_r.cfg_s2[0];

endmodule : vsc_regs

// >>> verification/vsc_host.sv
// Bus master model that writes the register bank over the two-wire bus
`timescale 1ns/100ps
module vsc_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// Clock cycles per quarter bit; 25 keeps each half period at 5 us
	int half = 25;

	initial begin
		scl_o <= 1'b1;
		sda_o <= 1'b1;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tk

	// Data changes only while the bus clock is low
	task automatic put(input logic [7:0] b, inout int acks);
		for (int i = 7; i >= 0; i--) begin
			sda_o <= b[i];
			tk(half);
			scl_o <= 1'b1;
			tk(2 * half);
			scl_o <= 1'b0;
			tk(half);
		end
		sda_o <= 1'b1;
		tk(half);
		scl_o <= 1'b1;
		tk(half);
		acks += (sda_i === 1'b0);
		tk(half);
		scl_o <= 1'b0;
		tk(half);
	endtask : put

	task automatic xfer(input logic [6:0] a, input logic [7:0] s,
		input logic [7:0] q[$], output int acks);
		acks = 0;
		sda_o <= 1'b0;
		tk(2 * half);
		scl_o <= 1'b0;
		tk(half);
		put({a, 1'b0}, acks);
		put(s, acks);
		foreach (q[k]) begin
			put(q[k], acks);
		end
		sda_o <= 1'b0;
		tk(half);
		scl_o <= 1'b1;
		tk(2 * half);
		sda_o <= 1'b1;
		tk(2 * half);
	endtask : xfer
endmodule : vsc_host

// >>> verification/vsc_regs_chk.sv
// Concurrent checks on the ports of the register bank
`timescale 1ns/100ps
module vsc_regs_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic conversion_select_pin_i,
	input wire logic sda_oe_o,
	input wire vsc_pkg::vsc_ctl1_t ctl1_o,
	input wire vsc_pkg::vsc_ctl2_t ctl2_o,
	input wire vsc_pkg::vsc_ctl3_t ctl3_o,
	input wire vsc_pkg::vsc_zoom_t zoom_o,
	input wire vsc_pkg::vsc_phase_t phase_o,
	input wire vsc_pkg::vsc_border_t border_o,
	input wire vsc_pkg::vsc_hold_t hold_o,
	input wire logic conversion_active_o,
	input wire logic raster_undef_o,
	input wire logic write_delay_undef_o,
	input wire logic window_illegal_o,
	input wire logic zoom_column_undef_o,
	input wire logic [9:0] line_length_o,
	input wire logic [9:0] line_sync_cycles_o,
	input wire logic [4:0] hold_lead_o
);
	import vsc_pkg::*;
	a_reset_clear: assert property (
		@(posedge clk_i) rst_i |=> !sda_oe_o && {ctl1_o, ctl2_o, ctl3_o,
		zoom_o, phase_o, border_o, hold_o} == 56'h0)
		else $error("registers not cleared by reset");
	a_line_len: assert property (
		@(posedge clk_i) disable iff (rst_i) ctl1_o.std_sel |->
		line_length_o == (phase_o.long_line_sel ? LINE_LONG : LINE_SHORT))
		else $error("line length wrong");
	a_sync_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		line_sync_cycles_o == {phase_o.line_sync_shift, 3'h0})
		else $error("sync shift cycles wrong");
	a_hold_lead: assert property (
		@(posedge clk_i) disable iff (rst_i)
		hold_lead_o == {1'b0, hold_o.hold_pulse_position} + 5'h03)
		else $error("hold lead wrong");
	a_delay_undef: assert property (
		@(posedge clk_i) disable iff (rst_i)
		write_delay_undef_o == (ctl2_o.write_delay[3:0] == 4'hf))
		else $error("write delay flag wrong");
	a_zoom_undef: assert property (
		@(posedge clk_i) disable iff (rst_i)
		zoom_column_undef_o == (zoom_o.zoom_column[3:2] == 2'h3))
		else $error("zoom column flag wrong");
	a_raster_undef: assert property (
		@(posedge clk_i) disable iff (rst_i) raster_undef_o ==
		(ctl1_o.raster_sequence == 2'h3 || (ctl1_o.raster_sequence ==
		2'h2 && !conversion_active_o)))
		else $error("raster flag wrong");
	a_window_ok: assert property (
		@(posedge clk_i) disable iff (rst_i) window_illegal_o ==
		(ctl3_o.window_row == 2'h3 || ctl3_o.window_column == 2'h3 ||
		(ctl3_o.write_mode_sel >= WR_PIC_IN_STILL &&
		(ctl3_o.window_row == 2'h1 || ctl3_o.window_column == 2'h1))))
		else $error("window flag wrong");
	a_conv_follow: assert property (
		@(posedge clk_i) disable iff (rst_i)
		$changed(conversion_select_pin_i) |->
		##[1:4] conversion_active_o == conversion_select_pin_i)
		else $error("conversion does not follow pin");
endmodule : vsc_regs_chk

bind vsc_regs vsc_regs_chk vsc_regs_chk_i (.clk_i, .rst_i,
	.conversion_select_pin_i, .sda_oe_o, .ctl1_o, .ctl2_o, .ctl3_o,
	.zoom_o, .phase_o, .border_o, .hold_o, .conversion_active_o,
	.raster_undef_o, .write_delay_undef_o, .window_illegal_o,
	.zoom_column_undef_o, .line_length_o, .line_sync_cycles_o,
	.hold_lead_o);

// >>> verification/vsc_regs_test.sv
// Self-checking bench for the video sync control register bank
`timescale 1ns/100ps
module vsc_regs_test;
	import vsc_pkg::*;
	logic clk_i, rst_i, lclk, addr_sel, conv_pin, vs_disp, vs_filt, sel;
	logic scl, host_sda, sda_oe, sda_w, zoom_act, frc_low, sw_out;
	logic conv_act, shown, f, e;
	logic [7:0] m [7] = '{default: 8'h00};
	logic [7:0] s, b;
	logic [6:0] dev;
	wire [55:0] all_w;
	logic [7:0] q [$];
	int fails, tests_run, cyc, acks;
	assign sda_w = host_sda & ~sda_oe;
	vsc_host vsc_host_i (.clk_i, .sda_i(sda_w), .scl_o(scl),
		.sda_o(host_sda));
	vsc_regs vsc_regs_i (.clk_i, .rst_i, .scl_i(scl), .sda_i(sda_w),
		.sda_o(), .sda_oe_o(sda_oe), .addr_sel_i(addr_sel),
		.conversion_select_pin_i(conv_pin), .ctl1_o(all_w[55:48]),
		.ctl2_o(all_w[47:40]), .ctl3_o(all_w[39:32]),
		.zoom_o(all_w[31:24]), .phase_o(all_w[23:16]),
		.border_o(all_w[15:8]), .hold_o(all_w[7:0]),
		.conversion_active_o(conv_act), .shown_field_o(shown),
		.raster_undef_o(), .write_delay_undef_o(), .window_illegal_o(),
		.zoom_column_undef_o(), .line_length_o(), .line_sync_cycles_o(),
		.hold_lead_o(), .base_pixel_clock_i(lclk),
		.display_vertical_sync_i(vs_disp),
		.filtered_vertical_sync_i(vs_filt), .source_switch_out_o(sw_out),
		.zoom_active_o(zoom_act), .border_signal_force_low_o(frc_low));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	// A hung bus transfer ends the run here
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			test_done();
		end
	end

	task automatic chk(input string n, input logic [9:0] ex,
		input logic [9:0] g);
		tests_run++;
		if (g !== ex) begin
			fails++;
			$display("Error %s expected %h seen %h", n, ex, g);
		end
	endtask : chk
	task automatic regs_chk;
		for (int r = 0; r < REG_N; r++) begin
			chk("register", m[r], all_w[55 - 8 * r -: 8]);
		end
	endtask : regs_chk
	// The model only takes bytes of a transfer that should be answered
	task automatic wr(input logic [6:0] a, input logic [7:0] sa,
		input int n);
		logic [7:0] p;
		vsc_host_i.xfer(a, sa, q, acks);
		chk("acks", 10'(n), 10'(acks));
		p = sa;
		foreach (q[k]) begin
			if (n > 0 && p < REG_N) begin
				m[p] = q[k];
			end
			p++;
		end
		repeat (5) @(posedge clk_i);
	endtask : wr
	task automatic test_done;
		$display("Comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	initial begin
		void'($urandom(47300));
		{rst_i, addr_sel, conv_pin, vs_disp, vs_filt} = 5'h10;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		regs_chk();
		for (int i = 0; i < 4; i++) begin
			s = (i == 1) ? 8'h05 : 8'h00;
			sel = 1'($urandom_range(1));
			dev = sel ? DEV_ADDR_HI : DEV_ADDR_LO;
			addr_sel <= sel;
			conv_pin <= 1'($urandom_range(1));
			vsc_host_i.half = (i == 3) ? 40 : 25;
			q.delete();
			for (int k = 0; k < 7; k++) begin
				b = 8'($urandom);
				// Middle position is kept out only in the inset modes
				if (s + k == 2 && b[5]) begin
					b = b & 8'hfa;
				end
				q.push_back(b);
			end
			wr(dev, s, 9);
			regs_chk();
			chk("conversion", conv_pin, conv_act);
			if (m[1][7] & m[1][5]) begin
				chk("field", m[1][6], shown);
			end
			repeat (4) @(posedge lclk);
			chk("zoom", m[3][7], zoom_act);
			chk("border", m[5][7], frc_low);
		end
		wr(dev ^ 7'h01, 8'h00, 0);
		regs_chk();
		for (int c = 0; c < 4; c++) begin
			q = '{{2'h0, 2'(c), 4'h0}};
			wr(dev, 8'h00, 3);
			repeat (2) begin
				@(posedge lclk);
				f = 1'($urandom_range(1));
				vs_filt <= f;
				repeat (3) @(posedge lclk);
				vs_disp <= 1'b1;
				repeat (8) @(posedge lclk);
				vs_disp <= 1'b0;
				e = c[0] ? (f ? c[1] : !c[1]) : c[1];
				chk("switch", e, sw_out);
			end
		end
		test_done();
	end
endmodule : vsc_regs_test
